// ==== gdct_consts.svh ====
// Register indices, field positions, reset values and timing counts
`ifndef GDCT_CONSTS_SVH
`define GDCT_CONSTS_SVH

// Register indices; byte address is four times the index
`define GDCT_IDX_HIGH 10'h0f0
`define GDCT_IDX_LOW 10'h0f1
`define GDCT_IDX_PSC 10'h0f2
`define GDCT_IDX_CTRL 10'h0f3
`define GDCT_IDX_AUX 10'h0f4

// Control byte fields
`define GDCT_RUN 7
`define GDCT_SC 6
`define GDCT_INMD_HI 5
`define GDCT_INMD_LO 4
`define GDCT_INPUT_ENABLE_BIT 3
`define GDCT_INTERRUPT_SOURCE_SELECT 2
`define GDCT_OUT_HI 1
`define GDCT_OUT_LO 0

// Auxiliary byte: event counter mode counts the oscillator clock
`define GDCT_AUX_OSC 0

// Reset values
`define GDCT_RST_BYTE 8'hff
`define GDCT_RST_CNT 16'hffff
`define GDCT_RST_CTRL 8'h14
`define GDCT_RST_AUX 8'h00

// Internal clock divided by 4: terminal count of the divider
`define GDCT_INT_DIV_LAST 2'h3
// Oscillator-derived clock divide ratio minus one
`define GDCT_OSC_DIV_LAST 4'h7

`endif

// ==== gdct_pkg.sv ====
// Types shared by the general down counter timer
`default_nettype none
package gdct_pkg;
    // Order matches the two input mode select bits
    typedef enum logic [1:0] {
        GDCT_EVENT,
        GDCT_GATED,
        GDCT_TRIG,
        GDCT_RETRIG
    } gdct_mode_t;
endpackage
`default_nettype wire

// ==== gdct_timer.sv ====
// General 16-bit down counter timer with 8-bit prescaler, APB slave
//
// Summary of operation
// R1: 16-bit down counter fed by 8-bit prescaler, single or continuous.
// R2: Prescaler clock: internal clock / 4, oscillator clock, or event pin.
// R3: End of count is the counter underflowing from zero.
// R4: Each end of count can request an external interrupt channel.
// R5: Control bit 7 runs the counter from next cycle; clearing stops it.
// R6: Restart resumes held value, or loads constant written while stopped.
// R7: Constant writes apply at next end of count; prescaler immediately.
// R8: Counter bytes and prescaler reset to all ones.
// R9: Bit 6 single mode: end of count stops, reloads, clears run bit.
// R10: Continuous mode reloads at end of count and keeps counting.
// R11: Single/continuous bit writable any time, together with run bit.
// R12: Input disabled: internal clock / 4 counts, event pin ignored.
// R13: Event counter mode: each falling event edge is one count clock.
// R14: Source spaces falling event edges at least eight clock periods.
// R15: Gated mode counts internal clock / 4 only while event pin high.
// R16: Triggerable mode starts on falling edge after run bit set.
// R17: Retriggerable mode: falling edge restarts from loaded constants.
// R18: Retriggerable mode ignores falling edges while run bit clear.
// R19: Output mode 00 drives the timer output pin high.
// R20: Square wave mode toggles the output pin at end of count.
// R21: PWM mode copies low output mode bit to pin at end of count.
// R22: Control bit 2 set routes external pin to channel, else timer.
// R23: Constant kept apart from live count; reads return live count.
// R24: Event input synchronised, falling edges found from synced samples.
`default_nettype none
`include "gdct_consts.svh"

module gdct_timer (
    input wire logic mclk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output var logic [31:0] prdata,
    output var logic pready,
    output var logic pslverr,
    input wire logic eventIn,
    input wire logic oscClkIn,
    input wire logic extIntIn,
    output var logic timerOut,
    output var logic intChannel
);
    logic [7:0] ctrl_ff;
    logic [7:0] aux_ff;
    logic [7:0] psc_ff;
    logic [7:0] pscCnt_ff;
    logic [15:0] cnt_ff;
    logic [15:0] reload_ff;
    logic [1:0] div4_ff;
    logic [3:0] oscDiv_ff;
    logic evS1_ff;
    logic evS2_ff;
    logic evS3_ff;
    logic oscS1_ff;
    logic oscS2_ff;
    logic oscS3_ff;
    logic extS1_ff;
    logic extS2_ff;
    logic armed_ff;
    logic pendLoad_ff;
    logic wrEn;
    logic rdSetup;
    logic selHigh;
    logic selLow;
    logic selPsc;
    logic selCtrl;
    logic selAux;
    logic mapped;
    logic runBit;
    logic inputEn;
    logic startEvt;
    logic intTick;
    logic oscTick;
    logic evFall;
    logic tick;
    logic cntEn;
    logic restart;
    logic reloadNow;
    logic eoc;
    gdct_pkg::gdct_mode_t mode;

    // APB decode; every access completes with one wait-free access phase
    assign selHigh = paddr[11:2] == `GDCT_IDX_HIGH;
    assign selLow = paddr[11:2] == `GDCT_IDX_LOW;
    assign selPsc = paddr[11:2] == `GDCT_IDX_PSC;
    assign selCtrl = paddr[11:2] == `GDCT_IDX_CTRL;
    assign selAux = paddr[11:2] == `GDCT_IDX_AUX;
    assign mapped = selHigh | selLow | selPsc | selCtrl | selAux;
    assign wrEn = psel & penable & pready & pwrite & mapped;
    assign rdSetup = psel & ~penable & ~pwrite;

    assign runBit = ctrl_ff[`GDCT_RUN];
    assign inputEn = ctrl_ff[`GDCT_INPUT_ENABLE_BIT];
    assign mode = gdct_pkg::gdct_mode_t'(
        {ctrl_ff[`GDCT_INMD_HI], ctrl_ff[`GDCT_INMD_LO]});
    assign startEvt = wrEn & selCtrl & pwdata[`GDCT_RUN] & ~runBit; // [R5]

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
        end
    end

    // Reads show live count and programmed prescaler
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            prdata <= 32'h0;
        else if (rdSetup)
        begin
            prdata <= 32'h0;
            if (selHigh)
                prdata[7:0] <= cnt_ff[15:8]; // [R23]
            if (selLow)
                prdata[7:0] <= cnt_ff[7:0]; // [R23]
            if (selPsc)
                prdata[7:0] <= psc_ff;
            if (selCtrl)
                prdata[7:0] <= ctrl_ff;
            if (selAux)
                prdata[7:0] <= aux_ff;
        end
    end

    // Software write wins over the single-mode self clear of the run bit
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            ctrl_ff <= `GDCT_RST_CTRL;
        else if (wrEn && selCtrl)
            ctrl_ff <= pwdata[7:0]; // [R11]
        else if (eoc && ctrl_ff[`GDCT_SC])
            ctrl_ff[`GDCT_RUN] <= 1'b0; // [R9]
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            aux_ff <= `GDCT_RST_AUX;
        else if (wrEn && selAux)
            aux_ff <= pwdata[7:0];
    end

    // Constant register, separate from the live count
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            reload_ff <= `GDCT_RST_CNT; // [R8]
            psc_ff <= `GDCT_RST_BYTE; // [R8]
        end
        else if (wrEn)
        begin
            if (selHigh)
                reload_ff[15:8] <= pwdata[7:0]; // [R23]
            if (selLow)
                reload_ff[7:0] <= pwdata[7:0];
            if (selPsc)
                psc_ff <= pwdata[7:0];
        end
    end

    // New constant written while stopped is loaded on restart
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            pendLoad_ff <= 1'b0;
        else if (startEvt)
            pendLoad_ff <= 1'b0; // [R6]
        else if (wrEn && (selHigh || selLow) && !runBit)
            pendLoad_ff <= 1'b1; // [R6]
    end

    // Synchronisers; first stage feeds only the second
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            evS1_ff <= 1'b1;
            evS2_ff <= 1'b1;
            evS3_ff <= 1'b1;
            oscS1_ff <= 1'b0;
            oscS2_ff <= 1'b0;
            oscS3_ff <= 1'b0;
            extS1_ff <= 1'b0;
            extS2_ff <= 1'b0;
        end
        else
        begin
            evS1_ff <= eventIn; // [R24]
            evS2_ff <= evS1_ff;
            evS3_ff <= evS2_ff;
            oscS1_ff <= oscClkIn;
            oscS2_ff <= oscS1_ff;
            oscS3_ff <= oscS2_ff;
            extS1_ff <= extIntIn;
            extS2_ff <= extS1_ff;
        end
    end
    assign evFall = evS3_ff & ~evS2_ff; // [R24]

    // Free-running divide by 4 of the internal clock
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            div4_ff <= 2'h0;
        else
            div4_ff <= div4_ff + 2'h1;
    end
    assign intTick = div4_ff == `GDCT_INT_DIV_LAST;

    // Oscillator-derived clock, divided after synchronising its edges
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            oscDiv_ff <= 4'h0;
        else if (oscS2_ff && !oscS3_ff)
        begin
            if (oscDiv_ff == `GDCT_OSC_DIV_LAST)
                oscDiv_ff <= 4'h0;
            else
                oscDiv_ff <= oscDiv_ff + 4'h1;
        end
    end
    assign oscTick = oscS2_ff & ~oscS3_ff
        & (oscDiv_ff == `GDCT_OSC_DIV_LAST);

    always_comb
    begin
        tick = intTick; // [R12]
        if (inputEn)
        begin
            case (mode)
                gdct_pkg::GDCT_EVENT:
                    tick = aux_ff[`GDCT_AUX_OSC] ? oscTick // [R2]
                        : evFall; // [R13]
                gdct_pkg::GDCT_GATED:
                    tick = intTick & evS2_ff; // [R15]
                default:
                    tick = intTick;
            endcase
        end
    end

    // Triggerable mode waits for a falling edge after the run bit
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            armed_ff <= 1'b0;
        else if (!runBit || !inputEn || mode != gdct_pkg::GDCT_TRIG)
            armed_ff <= 1'b0; // [R16]
        else if (evFall)
            armed_ff <= 1'b1; // [R16]
    end

    assign cntEn = runBit
        & (~inputEn | mode != gdct_pkg::GDCT_TRIG | armed_ff); // [R16]
    assign restart = inputEn & mode == gdct_pkg::GDCT_RETRIG
        & runBit & evFall; // [R17] [R18]
    assign reloadNow = (startEvt & pendLoad_ff) | restart; // [R6] [R17]
    assign eoc = cntEn & tick & ~reloadNow
        & pscCnt_ff == 8'h0 & cnt_ff == 16'h0; // [R3]

    // Prescaler write takes effect at once, even while running
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            pscCnt_ff <= `GDCT_RST_BYTE;
        else if (wrEn && selPsc)
            pscCnt_ff <= pwdata[7:0]; // [R7]
        else if (reloadNow)
            pscCnt_ff <= psc_ff;
        else if (cntEn && tick)
        begin
            if (pscCnt_ff == 8'h0)
                pscCnt_ff <= psc_ff;
            else
                pscCnt_ff <= pscCnt_ff - 8'h1; // [R1]
        end
    end

    // Live count; constant enters only at end of count or restart
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            cnt_ff <= `GDCT_RST_CNT; // [R8]
        else if (reloadNow)
            cnt_ff <= reload_ff; // [R6] [R17]
        else if (cntEn && tick && pscCnt_ff == 8'h0)
        begin
            if (cnt_ff == 16'h0)
                cnt_ff <= reload_ff; // [R7] [R10]
            else
                cnt_ff <= cnt_ff - 16'h1; // [R1]
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            timerOut <= 1'b1;
        else if (!ctrl_ff[`GDCT_OUT_HI] && !ctrl_ff[`GDCT_OUT_LO])
            timerOut <= 1'b1; // [R19]
        else if (eoc && !ctrl_ff[`GDCT_OUT_HI])
            timerOut <= ~timerOut; // [R20]
        else if (eoc)
            timerOut <= ctrl_ff[`GDCT_OUT_LO]; // [R21]
    end

    // Selection change may glitch the channel; software masks it first
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            intChannel <= 1'b0;
        else if (ctrl_ff[`GDCT_INTERRUPT_SOURCE_SELECT])
            intChannel <= extS2_ff; // [R22]
        else
            intChannel <= eoc; // [R4] [R22]
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    a_eoc_reload: assert property ( // [R10]
        eoc |=> cnt_ff == $past(reload_ff))
        else $error("count not reloaded at end of count");
    a_single_stop: assert property ( // [R9]
        eoc && ctrl_ff[`GDCT_SC] && !(wrEn && selCtrl) |=> !runBit)
        else $error("single mode did not clear run bit");
    a_psc_write: assert property ( // [R7]
        wrEn && selPsc |=> pscCnt_ff == $past(pwdata[7:0]))
        else $error("prescaler write not immediate");
    a_internal_step: assert property ( // [R12]
        !inputEn && runBit && intTick && !wrEn && pscCnt_ff == 8'h0
        && cnt_ff != 16'h0 |=> cnt_ff == $past(cnt_ff) - 16'h1)
        else $error("disabled input did not count internal clock");
    a_gate_hold: assert property ( // [R15]
        inputEn && mode == gdct_pkg::GDCT_GATED && !evS2_ff
        && !wrEn && !restart |=> $stable(cnt_ff) && $stable(pscCnt_ff))
        else $error("gated counter moved while gate low");
    a_stopped_stable: assert property ( // [R18]
        !runBit && !wrEn |=> $stable(cnt_ff))
        else $error("stopped counter changed");
    a_trig_wait: assert property ( // [R16]
        inputEn && mode == gdct_pkg::GDCT_TRIG && !armed_ff |-> !cntEn)
        else $error("triggerable mode counted before trigger");
    a_event_tick: assert property ( // [R13]
        inputEn && mode == gdct_pkg::GDCT_EVENT
        && !aux_ff[`GDCT_AUX_OSC] |-> tick == evFall)
        else $error("event edge did not clock counter");
    a_square_toggle: assert property ( // [R20]
        eoc && !ctrl_ff[`GDCT_OUT_HI] && ctrl_ff[`GDCT_OUT_LO]
        |=> timerOut != $past(timerOut))
        else $error("square wave did not toggle");
    a_pwm_copy: assert property ( // [R21]
        eoc && ctrl_ff[`GDCT_OUT_HI]
        |=> timerOut == $past(ctrl_ff[`GDCT_OUT_LO]))
        else $error("pwm level not copied");
    a_output_idle: assert property ( // [R19]
        !ctrl_ff[`GDCT_OUT_HI] && !ctrl_ff[`GDCT_OUT_LO] |=> timerOut)
        else $error("idle output not high");
    a_irq_route: assert property ( // [R22]
        !ctrl_ff[`GDCT_INTERRUPT_SOURCE_SELECT] |=> intChannel == $past(eoc))
        else $error("end of count not routed to channel");
    a_retrig_load: assert property ( // [R17]
        restart |=> cnt_ff == $past(reload_ff))
        else $error("retrigger did not reload");
endmodule
`default_nettype wire

// ==== gdct_event_src.sv ====
// Far-side model driving the event, oscillator and interrupt pins
`default_nettype none
module gdct_event_src (
    input wire logic mclk,
    output var logic eventIn,
    output var logic oscClkIn,
    output var logic extIntIn
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] oscDiv;
    initial
    begin
        eventIn = 1'b1;
        extIntIn = 1'b0;
        oscDiv = 2'h0;
    end
    // Slow free-running oscillator so level sampling cannot alias
    assign oscClkIn = oscDiv[1];
    always @(posedge mclk)
        oscDiv <= oscDiv + 2'h1;
    // Falling edges spaced nine cycles apart
    task automatic edges(input int n);
        repeat (n)
        begin
            @(posedge mclk);
            eventIn <= 1'b0;
            repeat (4) @(posedge mclk);
            eventIn <= 1'b1;
            repeat (4) @(posedge mclk);
        end
    endtask
    task automatic level(input logic v);
        @(posedge mclk);
        eventIn <= v;
    endtask
    task automatic ext(input logic v);
        @(posedge mclk);
        extIntIn <= v;
    endtask
endmodule
`default_nettype wire

// ==== general_down_counter_timer_tb_top.sv ====
// Self-checking bench for the general down counter timer
`default_nettype none
`include "gdct_consts.svh"
module general_down_counter_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk, rst, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, rdPrev;
    logic eventIn, oscClkIn, extIntIn, timerOut, intChannel;
    logic lastOut = 1'b1;
    int err_count = 0;
    int checks_done = 0;
    int pulses = 0;
    int toggles = 0;
    int cyc = 0;
    int lastPulse = 0;
    int period = 0;

    gdct_timer DUT (.mclk(mclk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .eventIn(eventIn), .oscClkIn(oscClkIn),
        .extIntIn(extIntIn), .timerOut(timerOut),
        .intChannel(intChannel));
    gdct_event_src src (.mclk(mclk), .eventIn(eventIn),
        .oscClkIn(oscClkIn), .extIntIn(extIntIn));

    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        lastOut <= timerOut;
        if (timerOut !== lastOut)
            toggles <= toggles + 1;
        if (intChannel === 1'b1)
        begin
            pulses <= pulses + 1;
            period <= cyc - lastPulse;
            lastPulse <= cyc;
        end
    end

    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic xfer(input logic wr, input logic [9:0] idx,
        input logic [31:0] wd);
        logic ok;
        ok = 1'b0;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'h0};
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        // Read at the edge, before that edge's own updates land
        while (!ok)
        begin
            @(posedge mclk);
            ok = (pready === 1'b1);
            rd = prdata;
            err = pslverr;
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        xfer(1'b1, idx, {24'h0, d});
    endtask

    task automatic rdc(input string nm, input logic [9:0] idx,
        input logic [7:0] e);
        xfer(1'b0, idx, 32'h0);
        chk(nm, {24'h0, e}, rd);
    endtask

    task automatic waitc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // Cleared off the edge so the monitor's updates cannot collide
    task automatic clr;
        @(negedge mclk);
        pulses = 0;
        toggles = 0;
    endtask

    task automatic finish_test;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge mclk);
        err_count++;
        finish_test;
    end

    initial
    begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        rdc("high", `GDCT_IDX_HIGH, 8'hff);
        rdc("low", `GDCT_IDX_LOW, 8'hff);
        rdc("psc", `GDCT_IDX_PSC, 8'hff);
        rdc("ctrl", `GDCT_IDX_CTRL, 8'h14);
        rdc("aux", `GDCT_IDX_AUX, 8'h00);
        chk("outIdle", 32'h1, {31'h0, timerOut});
        xfer(1'b0, 10'h0f5, 32'h0);
        chk("unmapErr", 32'h1, {31'h0, err});
        chk("unmapData", 32'h0, rd);
        wr(`GDCT_IDX_PSC, 8'h00);
        wr(`GDCT_IDX_HIGH, 8'h00);
        wr(`GDCT_IDX_LOW, 8'h03);
        wr(`GDCT_IDX_CTRL, 8'h81);
        clr;
        src.edges(6);
        waitc(40);
        chk("period16", 32'h10, period);
        chk("toggles", pulses, toggles);
        wr(`GDCT_IDX_PSC, 8'h01);
        waitc(80);
        chk("period32", 32'h20, period);
        rdc("pscRead", `GDCT_IDX_PSC, 8'h01);
        xfer(1'b0, `GDCT_IDX_LOW, 32'h0);
        rdPrev = rd;
        waitc(8);
        xfer(1'b0, `GDCT_IDX_LOW, 32'h0);
        chk("liveMoves", 32'h1, {31'h0, rd !== rdPrev});
        wr(`GDCT_IDX_CTRL, 8'h01);
        waitc(2);
        clr;
        wr(`GDCT_IDX_CTRL, 8'hc1);
        waitc(120);
        chk("single", 32'h1, pulses);
        rdc("runCleared", `GDCT_IDX_CTRL, 8'h41);
        wr(`GDCT_IDX_PSC, 8'h00);
        wr(`GDCT_IDX_LOW, 8'h01);
        wr(`GDCT_IDX_CTRL, 8'h89);
        clr;
        src.edges(6);
        waitc(8);
        chk("events", 32'h3, pulses);
        wr(`GDCT_IDX_AUX, 8'h01);
        clr;
        waitc(300);
        chk("oscTicks", 32'h1, {31'h0, pulses >= 3});
        wr(`GDCT_IDX_AUX, 8'h00);
        src.level(1'b0);
        wr(`GDCT_IDX_CTRL, 8'h99);
        waitc(4);
        clr;
        waitc(80);
        chk("gatedLow", 32'h0, pulses);
        src.level(1'b1);
        clr;
        waitc(80);
        chk("gatedHigh", 32'h1, {31'h0, pulses >= 9 && pulses <= 11});
        wr(`GDCT_IDX_CTRL, 8'h29);
        wr(`GDCT_IDX_CTRL, 8'ha9);
        clr;
        waitc(60);
        chk("trigWait", 32'h0, pulses);
        src.edges(1);
        waitc(40);
        chk("trigGo", 32'h1, {31'h0, pulses > 0});
        wr(`GDCT_IDX_CTRL, 8'h39);
        wr(`GDCT_IDX_LOW, 8'h03);
        wr(`GDCT_IDX_CTRL, 8'hb9);
        clr;
        src.edges(10);
        chk("retrig", 32'h0, pulses);
        wr(`GDCT_IDX_CTRL, 8'h83);
        waitc(40);
        chk("pwmHigh", 32'h1, {31'h0, timerOut});
        wr(`GDCT_IDX_CTRL, 8'h82);
        waitc(40);
        chk("pwmLow", 32'h0, {31'h0, timerOut});
        wr(`GDCT_IDX_CTRL, 8'h04);
        waitc(2);
        chk("outOff", 32'h1, {31'h0, timerOut});
        src.ext(1'b1);
        waitc(4);
        chk("extHigh", 32'h1, {31'h0, intChannel});
        src.ext(1'b0);
        waitc(4);
        chk("extLow", 32'h0, {31'h0, intChannel});
        finish_test;
    end
endmodule
`default_nettype wire
